// file: hdl/memdec_defines.vh
/*
 memory decoder constants: register offsets, field positions, reset values,
 and memory map boundaries. assumes inclusion by bare name from hdl files.
*/
`ifndef MEMDEC_DEFINES_VH
`define MEMDEC_DEFINES_VH
// =====================================================
// register map (byte addresses on the ahb-lite bus)
`define OFF_PROGRAM_BANK_SELECT 8'h84
`define OFF_STATUS_WORD 8'h88
`define OFF_ONCHIP_EXTERNAL_RAM_PAGE 8'h8C
`define OFF_STACK_POINTER 8'h90
`define OFF_CONFIG 8'h94
// =====================================================
// field positions and reset values
`define CB_LSB 4
`define FB_LSB 0
`define BANK_SEL_WMASK 8'h33
`define BANK_SEL_RESET 8'h00
`define STATUS_RS_LSB 3
`define STATUS_RESET 8'h00
`define SP_RESET 8'h07
`define ONCHIP_EXTERNAL_RAM_PAGE_RESET 8'h00
`define CFG_RESET 8'h00
// =====================================================
// memory map boundaries
`define UPPER_CODE_BIT 15
`define LOCK_LINEAR_ADDR 17'h1FFFF
`define BIT_AREA_BASE 8'h20
`define ONCHIP_EXTERNAL_RAM_BYTES 8192
`define IRAM_BYTES 256
`endif

// file: hdl/iram_bank.v
/*
 small synchronous ram: one write port, one read port, registered read data.
 assumes a single clock and a clock enable that freezes it.
*/
`default_nettype none
module iram_bank #(
    parameter DEPTH = 256,
    parameter AW = 8
) (
    input wire clk,
    input wire ce,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [7:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [7:0] rdata
);
    reg [7:0] mem [0:DEPTH-1];
    // =====================================================
    // storage; no reset so it maps onto block ram
    always @(posedge clk)
    begin
        if (ce)
        begin
            if (we)
                mem[waddr] <= wdata;
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// file: hdl/mem_decoder.v
/*
 address decoder for an 8051-style memory map: program bank resolution,
 internal ram / sfr / bit / stack routing and on-chip onchip_external_ram addressing.
 assumes the cpu core presents one request per cycle on clk, and software
 reaches the bank, status, page, stack and config registers over ahb-lite.
*/
// Chosen here: the AHB-Lite slave port.
//
// Contract
// - lower 32k program always maps bank zero
// - upper fetches use fetch bank field
// - fetch bank changes only from bank zero
// - upper constant/flash accesses use constant bank
// - fields at 5:4 and 1:0, reserved zero
// - top linear address is the lock byte
// - constants from flash; movx to onchip_external_ram unless configured
// - 256 byte internal ram, low half direct/indirect
// - above 0x7f direct=sfr, indirect=upper ram
// - r0-r7 in bank picked by status bits 4:3
// - indirect pointer comes from active r0/r1
// - bytes 0x20-0x2f hold 128 bit locations
// - bit versus byte from instruction type
// - push writes sp+1 then increments sp
// - stack pointer resets to 0x07
// - 8192 byte onchip_external_ram via data pointer or page
// - 8-bit movx uses page high, pointer low
`include "memdec_defines.vh"
`default_nettype none
module mem_decoder #(
    parameter ONCHIP_EXTERNAL_RAM_AW = 13
) (
    input wire clk,
    input wire rst,
    input wire ce,
    // ahb-lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // program side
    input wire [15:0] pc,
    input wire [15:0] code_addr,
    input wire code_is_fetch,
    output reg [16:0] flash_addr,
    output reg flash_is_lock,
    output reg flash_reserved,
    // data side request from core
    input wire data_req,
    input wire [7:0] data_addr,
    input wire data_indirect,
    input wire [2:0] ind_reg_sel,
    input wire data_is_bit,
    input wire data_we,
    input wire [7:0] data_wdata,
    input wire push,
    input wire pop,
    output reg [7:0] data_rdata,
    output reg sfr_sel,
    output reg [7:0] sfr_addr,
    // movx request
    input wire movx_req,
    input wire movx_use_data_pointer_16,
    input wire movx_r1,
    input wire movx_we,
    input wire [15:0] data_pointer_16,
    output reg [15:0] movx_addr,
    output reg movx_to_flash,
    output reg movx_onchip_external_ram_hit
);
    // =====================================================
    // registers
    reg [7:0] bank_sel_q;
    reg [7:0] status_q;
    reg [7:0] page_q;
    reg [7:0] sp_q;
    reg [7:0] cfg_q;
    reg [7:0] r0_shadow_q [0:3];
    reg [7:0] r1_shadow_q [0:3];
    reg ap_wr_q;
    reg [7:0] ap_addr_q;
    wire [1:0] fetch_bank_field = bank_sel_q[`FB_LSB+1:`FB_LSB];
    wire [1:0] constant_bank_field = bank_sel_q[`CB_LSB+1:`CB_LSB];
    wire [1:0] reg_bank = status_q[`STATUS_RS_LSB+1:`STATUS_RS_LSB];
    // code in bank zero: pc in common area or upper area mapped to bank 0
    wire exec_in_bank0 = ~pc[`UPPER_CODE_BIT] | (fetch_bank_field == 2'b00);
    // =====================================================
    // ahb-lite slave: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    wire ap_valid = hsel & hready & htrans[1];
    wire wr_phase = ap_wr_q;
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ap_wr_q <= 1'b0;
            ap_addr_q <= 8'h00;
        end
        else if (ce && hready)
        begin
            ap_wr_q <= ap_valid & hwrite;
            ap_addr_q <= haddr;
        end
    end
    // read data registered at the address phase; unmapped reads as zero
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            hrdata <= 32'h00000000;
        else if (ce && ap_valid && !hwrite)
        begin
            case (haddr)
                `OFF_PROGRAM_BANK_SELECT: hrdata <= {24'h000000, bank_sel_q & `BANK_SEL_WMASK};
                `OFF_STATUS_WORD: hrdata <= {24'h000000, status_q};
                `OFF_ONCHIP_EXTERNAL_RAM_PAGE: hrdata <= {24'h000000, page_q};
                `OFF_STACK_POINTER: hrdata <= {24'h000000, sp_q};
                `OFF_CONFIG: hrdata <= {24'h000000, cfg_q};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end
    // =====================================================
    // register writes and stack pointer
    wire [7:0] sp_inc = sp_q + 8'h01;
    wire [7:0] sp_dec = sp_q - 8'h01;
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bank_sel_q <= `BANK_SEL_RESET;
            status_q <= `STATUS_RESET;
            page_q <= `ONCHIP_EXTERNAL_RAM_PAGE_RESET;
            sp_q <= `SP_RESET;
            cfg_q <= `CFG_RESET;
        end
        else if (ce)
        begin
            if (wr_phase && ap_addr_q == `OFF_PROGRAM_BANK_SELECT)
            begin
                // constant field always; fetch field only from bank 0 code
                bank_sel_q[`CB_LSB+1:`CB_LSB] <= hwdata[`CB_LSB+1:`CB_LSB];
                if (exec_in_bank0)
                    bank_sel_q[`FB_LSB+1:`FB_LSB] <= hwdata[`FB_LSB+1:`FB_LSB];
            end
            if (wr_phase && ap_addr_q == `OFF_STATUS_WORD)
                status_q <= hwdata[7:0];
            if (wr_phase && ap_addr_q == `OFF_ONCHIP_EXTERNAL_RAM_PAGE)
                page_q <= hwdata[7:0];
            if (wr_phase && ap_addr_q == `OFF_CONFIG)
                cfg_q <= {7'h00, hwdata[0]};
            // push/pop win over a bus write in the same cycle
            if (data_req && push)
                sp_q <= sp_inc;
            else if (data_req && pop)
                sp_q <= sp_dec;
            else if (wr_phase && ap_addr_q == `OFF_STACK_POINTER)
                sp_q <= hwdata[7:0];
        end
    end
    // =====================================================
    // program memory bank resolution
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            flash_addr <= 17'h00000;
            flash_is_lock <= 1'b0;
            flash_reserved <= 1'b0;
        end
        else if (ce)
        begin
            if (!code_addr[`UPPER_CODE_BIT])
                flash_addr <= {2'b00, code_addr[14:0]};
            else if (code_is_fetch)
                flash_addr <= {fetch_bank_field, code_addr[14:0]};
            else
                flash_addr <= {constant_bank_field, code_addr[14:0]};
            flash_is_lock <= code_addr[`UPPER_CODE_BIT] &&
                {(code_is_fetch ? fetch_bank_field : constant_bank_field), code_addr[14:0]} ==
                `LOCK_LINEAR_ADDR;
            // nothing lies above the lock byte in a 17-bit space
            flash_reserved <= 1'b0;
        end
    end
    // =====================================================
    // r0/r1 shadows per bank, kept for pointer lookup
    wire [7:0] ptr_val = ind_reg_sel[0] ? r1_shadow_q[reg_bank] : r0_shadow_q[reg_bank];
    wire [7:0] reg_phys = {3'b000, reg_bank, 3'b000} + {5'h00, ind_reg_sel};
    wire [7:0] bit_byte = `BIT_AREA_BASE + {4'h0, data_addr[6:3]};
    reg [7:0] eff_addr;
    reg is_sfr;
    always @*
    begin
        eff_addr = data_addr;
        is_sfr = 1'b0;
        if (push)
            eff_addr = sp_inc;
        else if (pop)
            eff_addr = sp_q;
        else if (data_indirect)
            eff_addr = ptr_val;
        else if (data_is_bit)
        begin
            if (data_addr[7])
            begin
                eff_addr = {data_addr[7:3], 3'b000};
                is_sfr = 1'b1;
            end
            else
                eff_addr = bit_byte;
        end
        else if (data_addr[7])
            is_sfr = 1'b1;
    end
    wire ram_we = ce & data_req & data_we & ~is_sfr & ~data_is_bit & ~pop;
    integer i;
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (i = 0; i < 4; i = i + 1)
            begin
                r0_shadow_q[i] <= 8'h00;
                r1_shadow_q[i] <= 8'h00;
            end
        end
        else if (ram_we && eff_addr[7:5] == 3'b000 && eff_addr[2:1] == 2'b00)
        begin
            if (eff_addr[0])
                r1_shadow_q[eff_addr[4:3]] <= data_wdata;
            else
                r0_shadow_q[eff_addr[4:3]] <= data_wdata;
        end
    end
    wire [7:0] ram_q;
    iram_bank #(
        .DEPTH(`IRAM_BYTES),
        .AW(8)
    ) u_iram (
        .clk(clk),
        .ce(ce),
        .we(ram_we),
        .waddr(eff_addr),
        .wdata(data_wdata),
        .raddr(eff_addr),
        .rdata(ram_q)
    );
    // =====================================================
    // sfr routing and bit extraction on read data
    reg [2:0] bit_pos_q;
    reg bit_q;
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sfr_sel <= 1'b0;
            sfr_addr <= 8'h00;
            bit_pos_q <= 3'b000;
            bit_q <= 1'b0;
        end
        else if (ce)
        begin
            sfr_sel <= data_req & is_sfr;
            sfr_addr <= eff_addr;
            bit_pos_q <= data_addr[2:0];
            bit_q <= data_is_bit & ~data_indirect & ~push & ~pop;
        end
    end
    always @*
    begin
        if (bit_q)
            data_rdata = {7'h00, ram_q[bit_pos_q]};
        else
            data_rdata = ram_q;
    end
    // reg_phys is the working register address; no port carries it out, so it is only reduced here
    wire unused_reg_phys = ^reg_phys;
    // =====================================================
    // movx address formation and target choice
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            movx_addr <= 16'h0000;
            movx_to_flash <= 1'b0;
            movx_onchip_external_ram_hit <= 1'b0;
        end
        else if (ce)
        begin
            if (movx_use_data_pointer_16)
                movx_addr <= data_pointer_16;
            else
                movx_addr <= {page_q, movx_r1 ? r1_shadow_q[reg_bank] : r0_shadow_q[reg_bank]};
            movx_to_flash <= movx_req & movx_we & cfg_q[0];
            movx_onchip_external_ram_hit <= movx_req & ~(movx_we & cfg_q[0]) &
                ((movx_use_data_pointer_16 ? data_pointer_16[15:ONCHIP_EXTERNAL_RAM_AW] : page_q[7:ONCHIP_EXTERNAL_RAM_AW-8]) == 0);
        end
    end
endmodule
`default_nettype wire

// file: bench/mem_decoder_assertions.sv
/* checker for mem_decoder: decode relations seen at its ports.
   assumes ce is held high, so every request is taken. */
`default_nettype none
module mem_decoder_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] code_addr,
    input wire logic [16:0] flash_addr,
    input wire logic flash_is_lock,
    input wire logic data_req,
    input wire logic [7:0] data_addr,
    input wire logic data_indirect,
    input wire logic data_is_bit,
    input wire logic push,
    input wire logic pop,
    input wire logic sfr_sel,
    input wire logic [7:0] sfr_addr,
    input wire logic movx_req,
    input wire logic movx_use_data_pointer_16,
    input wire logic movx_we,
    input wire logic [15:0] data_pointer_16,
    input wire logic [15:0] movx_addr,
    input wire logic movx_onchip_external_ram_hit,
    input wire logic movx_to_flash
);
timeunit 1ns;
timeprecision 1ns;
default clocking @(posedge clk); endclocking
default disable iff (rst);
// ========
// decode properties, one cycle of latency each except p_lock, which compares two registered outputs in the same cycle
property p_low_bank;
    !code_addr[15] |=> flash_addr == {2'h0, $past(code_addr[14:0])};
endproperty
a_low_bank: assert property (p_low_bank) else $error("low code not bank zero");
property p_lock;
    flash_is_lock == (flash_addr == 17'h1FFFF);
endproperty
a_lock: assert property (p_lock) else $error("lock flag wrong");
property p_sfr_direct;
    data_req && !push && !pop && !data_indirect && !data_is_bit && data_addr[7] |=>
        sfr_sel && sfr_addr == $past(data_addr);
endproperty
a_sfr_direct: assert property (p_sfr_direct) else $error("direct high not sfr");
property p_low_direct;
    data_req && !data_indirect && !data_addr[7] |=> !sfr_sel;
endproperty
a_low_direct: assert property (p_low_direct) else $error("low ram went to sfr");
property p_indirect;
    data_req && data_indirect |=> !sfr_sel;
endproperty
a_indirect: assert property (p_indirect) else $error("indirect went to sfr");
property p_bit_sfr;
    data_req && !push && !pop && data_is_bit && !data_indirect && data_addr[7] |=>
        sfr_sel && sfr_addr == {$past(data_addr[7:3]), 3'h0};
endproperty
a_bit_sfr: assert property (p_bit_sfr) else $error("sfr bit byte wrong");
property p_data_pointer_16;
    movx_req && movx_use_data_pointer_16 |=> movx_addr == $past(data_pointer_16);
endproperty
a_data_pointer_16: assert property (p_data_pointer_16) else $error("movx address wrong");
property p_onchip_external_ram_hit;
    movx_req && movx_use_data_pointer_16 && !movx_we && data_pointer_16 < 16'h2000 |=> movx_onchip_external_ram_hit;
endproperty
a_onchip_external_ram_hit: assert property (p_onchip_external_ram_hit) else $error("onchip_external_ram miss");
property p_read_onchip_external_ram;
    movx_req && !movx_we |=> !movx_to_flash;
endproperty
a_read_onchip_external_ram: assert property (p_read_onchip_external_ram) else $error("movx read to flash");
// main scenarios reached
c_lock: cover property (flash_is_lock);
c_sfr: cover property (sfr_sel);
c_flash: cover property (movx_to_flash);
endmodule
`default_nettype wire

// file: bench/core_model.sv
/* model of the cpu core request side of mem_decoder.
   assumes clk is the decoder clock; requests last one cycle. */
`default_nettype none
module core_model (
    input wire logic clk,
    output logic [15:0] pc,
    output logic [15:0] code_addr,
    output logic code_is_fetch,
    output logic data_req,
    output logic [7:0] data_addr,
    output logic data_indirect,
    output logic [2:0] ind_reg_sel,
    output logic data_is_bit,
    output logic data_we,
    output logic [7:0] data_wdata,
    output logic push,
    output logic pop,
    output logic movx_req,
    output logic movx_use_data_pointer_16,
    output logic movx_r1,
    output logic movx_we,
    output logic [15:0] data_pointer_16
);
timeunit 1ns;
timeprecision 1ns;
// ========
// idle at time zero
initial
begin
    {pc, code_addr, code_is_fetch, data_req, data_addr, data_indirect, ind_reg_sel} = '0;
    {data_is_bit, data_we, data_wdata, push, pop, movx_req, movx_use_data_pointer_16, movx_r1, movx_we} = '0;
    data_pointer_16 = '0;
end
// program address; pc stays as a level
task automatic code(input logic [15:0] p, a, input logic f);
    @(posedge clk);
    pc <= p;
    code_addr <= a;
    code_is_fetch <= f;
    @(posedge clk);
    #1; // registered outputs settle before the caller looks
endtask
// k = {indirect, bit, write, push, pop}; stack ops ride on data_req too, a push also sets write
task automatic dat(input logic [7:0] a, d, input logic [4:0] k);
    @(posedge clk);
    data_req <= 1'h1;
    data_addr <= a;
    ind_reg_sel <= a[2:0];
    data_wdata <= d;
    {data_indirect, data_is_bit, data_we, push, pop} <= k;
    @(posedge clk);
    data_req <= 1'h0;
    {data_we, push, pop} <= 3'h0;
    data_addr <= ~a; // stale values must not be relied on
    data_wdata <= ~d;
    #1; // read data and routing flops settle before the caller looks
endtask
// k = {use pointer, r1, write}
task automatic mx(input logic [15:0] dp, input logic [2:0] k);
    @(posedge clk);
    movx_req <= 1'h1;
    data_pointer_16 <= dp;
    {movx_use_data_pointer_16, movx_r1, movx_we} <= k;
    @(posedge clk);
    movx_req <= 1'h0;
    data_pointer_16 <= ~dp;
    #1; // movx outputs settle before the caller looks
endtask
endmodule
`default_nettype wire

// file: bench/test_mem_decoder.sv
/* self-checking bench for mem_decoder over ahb-lite and the core model.
   assumes the checker and core model files are compiled first. */
`default_nettype none
module test_mem_decoder;
timeunit 1ns;
timeprecision 1ns;
logic clk = 1'h0;
logic rst = 1'h1;
logic hwrite = 1'h0;
logic [1:0] htrans = 2'h0;
logic [7:0] haddr = 8'h00;
logic [31:0] hwdata = 32'h0;
logic [7:0] rdv;
int n_mismatch = 0;
int total_checks = 0;
wire [15:0] pc, code_addr, data_pointer_16, movx_addr;
wire [7:0] data_addr, data_wdata, data_rdata, sfr_addr;
wire [16:0] flash_addr;
wire [2:0] ind_reg_sel;
wire [31:0] hrdata;
wire code_is_fetch, data_req, data_indirect, data_is_bit, data_we, push, pop;
wire movx_req, movx_use_data_pointer_16, movx_r1, movx_we, flash_is_lock, sfr_sel;
wire movx_to_flash, movx_onchip_external_ram_hit, hreadyout, hresp, hready, flash_reserved;
assign hready = hreadyout; // single slave drives the bus ready
mem_decoder mem_decoder_i (.clk(clk), .rst(rst), .ce(1'h1), .hsel(1'h1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pc(pc), .code_addr(code_addr),
    .code_is_fetch(code_is_fetch), .flash_addr(flash_addr), .flash_is_lock(flash_is_lock),
    .flash_reserved(flash_reserved), .data_req(data_req), .data_addr(data_addr), .data_indirect(data_indirect),
    .ind_reg_sel(ind_reg_sel), .data_is_bit(data_is_bit), .data_we(data_we), .data_wdata(data_wdata),
    .push(push), .pop(pop), .data_rdata(data_rdata), .sfr_sel(sfr_sel), .sfr_addr(sfr_addr),
    .movx_req(movx_req), .movx_use_data_pointer_16(movx_use_data_pointer_16), .movx_r1(movx_r1), .movx_we(movx_we),
    .data_pointer_16(data_pointer_16), .movx_addr(movx_addr), .movx_to_flash(movx_to_flash),
    .movx_onchip_external_ram_hit(movx_onchip_external_ram_hit));
core_model core_model_i (.clk(clk), .pc(pc), .code_addr(code_addr), .code_is_fetch(code_is_fetch),
    .data_req(data_req), .data_addr(data_addr), .data_indirect(data_indirect), .ind_reg_sel(ind_reg_sel),
    .data_is_bit(data_is_bit), .data_we(data_we), .data_wdata(data_wdata), .push(push), .pop(pop),
    .movx_req(movx_req), .movx_use_data_pointer_16(movx_use_data_pointer_16), .movx_r1(movx_r1), .movx_we(movx_we),
    .data_pointer_16(data_pointer_16));
// 20 MHz clock
always #25 clk = ~clk;
// ========
// shared tasks
task chk(input logic [31:0] g, e);
    total_checks++;
    if (g !== e)
    begin
        n_mismatch++;
        $display("Error %0t got %h expected %h", $time, g, e);
    end
endtask
// single ahb transfer; waits on hready, read data taken at data phase end
task ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'h1);
    rdv = hrdata[7:0];
    #1;
endtask
task end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask
// ========
// scenarios
task t_reset;
    ahb(8'h84, 1'h0, 32'h0);
    chk(rdv, 8'h00);
    ahb(8'h90, 1'h0, 32'h0);
    chk(rdv, 8'h07);
    ahb(8'hFC, 1'h0, 32'h0);
    chk(rdv, 8'h00);
    chk(hresp, 1'h0);
    $display("t_reset done");
endtask
// fetch and constant fields set apart so a swap shows
task t_bank;
    for (int i = 0; i < 4; i++)
    begin
        ahb(8'h84, 1'h1, (3 - i) * 16 + i);
        ahb(8'h84, 1'h0, 32'h0);
        chk(rdv, (3 - i) * 16 + i);
        core_model_i.code(16'h0100, 16'h9234, 1'h1);
        chk(flash_addr, i * 32768 + 32'h1234);
        core_model_i.code(16'h0100, 16'h9234, 1'h0);
        chk(flash_addr, (3 - i) * 32768 + 32'h1234);
        core_model_i.code(16'h0100, 16'h1234, 1'h1);
        chk(flash_addr, 32'h1234);
    end
    core_model_i.code(16'h8100, 16'hFFFF, 1'h1);
    chk(flash_is_lock, 1'h1);
    chk(flash_reserved, 1'h0);
    ahb(8'h84, 1'h1, 32'h10);
    ahb(8'h84, 1'h0, 32'h0);
    chk(rdv, 8'h13);
    core_model_i.code(16'h8100, 16'h9234, 1'h1);
    chk(flash_addr, 32'h19234);
    $display("t_bank done");
endtask
task t_data;
    core_model_i.dat(8'h00, 8'hA5, 5'h06);
    ahb(8'h90, 1'h0, 32'h0);
    chk(rdv, 8'h08);
    core_model_i.dat(8'h08, 8'h00, 5'h00);
    chk(data_rdata, 8'hA5);
    core_model_i.dat(8'h00, 8'h00, 5'h01);
    chk(data_rdata, 8'hA5);
    ahb(8'h88, 1'h1, 32'h10);
    core_model_i.dat(8'h10, 8'h85, 5'h04);
    core_model_i.dat(8'h00, 8'h3C, 5'h14);
    core_model_i.dat(8'h85, 8'h00, 5'h00);
    chk(sfr_sel, 1'h1);
    core_model_i.dat(8'h00, 8'h00, 5'h10);
    chk(data_rdata, 8'h3C);
    core_model_i.dat(8'h22, 8'h08, 5'h04);
    core_model_i.dat(8'h13, 8'h00, 5'h08);
    chk(data_rdata[0], 1'h1);
    core_model_i.dat(8'h12, 8'h00, 5'h08);
    chk(data_rdata[0], 1'h0);
    core_model_i.dat(8'hE1, 8'h00, 5'h08);
    chk(sfr_addr, 8'hE0);
    $display("t_data done");
endtask
task t_movx;
    ahb(8'h8C, 1'h1, 32'h12);
    core_model_i.dat(8'h11, 8'h34, 5'h04);
    core_model_i.mx(16'h0000, 3'h2);
    chk(movx_addr, 16'h1234);
    core_model_i.mx(16'h2000, 3'h4);
    chk(movx_onchip_external_ram_hit, 1'h0);
    core_model_i.mx(16'h1FFF, 3'h4);
    chk(movx_onchip_external_ram_hit, 1'h1);
    ahb(8'h94, 1'h1, 32'h1);
    core_model_i.mx(16'h8000, 3'h5);
    chk(movx_to_flash, 1'h1);
    $display("t_movx done");
endtask
// main sequence
initial
begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    t_reset;
    t_bank;
    t_data;
    t_movx;
    end_sim;
end
// watchdog, far beyond the roughly 125 cycles the tests need
initial
begin
    #200000;
    n_mismatch++;
    end_sim;
end
endmodule
bind mem_decoder mem_decoder_assertions mem_decoder_assertions_i (.clk(clk), .rst(rst),
    .code_addr(code_addr), .flash_addr(flash_addr), .flash_is_lock(flash_is_lock),
    .data_req(data_req), .data_addr(data_addr), .data_indirect(data_indirect),
    .data_is_bit(data_is_bit), .push(push), .pop(pop), .sfr_sel(sfr_sel), .sfr_addr(sfr_addr), .movx_req(movx_req),
    .movx_use_data_pointer_16(movx_use_data_pointer_16), .movx_we(movx_we), .data_pointer_16(data_pointer_16),
    .movx_addr(movx_addr), .movx_onchip_external_ram_hit(movx_onchip_external_ram_hit), .movx_to_flash(movx_to_flash));
`default_nettype wire
